// File: common/dmr_pkg.sv
// Constants, field layouts and carrier types for the mode-register block
package dmr_pkg;

  localparam int ADDR_W = 13;
  localparam int BA_W = 3;

  // Bank-address codes of the mode-register family
  localparam logic [2:0] BA_MR = 3'h0;
  localparam logic [2:0] BA_EMR1 = 3'h1;
  localparam logic [2:0] BA_EMR2 = 3'h2;
  localparam logic [2:0] BA_EMR3 = 3'h3;

  // Operating mode register fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_POS = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_TM_POS = 7;
  localparam int MR_DLLRST_POS = 8;
  localparam int MR_WR_LSB = 9;

  // Extended mode register one fields
  localparam int E1_DLL_POS = 0;
  localparam int E1_DS_POS = 1;
  localparam int E1_ODT0_POS = 2;
  localparam int E1_AL_LSB = 3;
  localparam int E1_ODT1_POS = 6;
  localparam int E1_OCD_LSB = 7;
  localparam int E1_DQSN_POS = 10;
  localparam int E1_RDQS_POS = 11;
  localparam int E1_QOFF_POS = 12;

  // Legal burst-length codes
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  // Supported CAS-latency code range (whole clocks only)
  localparam logic [2:0] CL_CODE_MIN = 3'h2;
  localparam logic [2:0] CL_CODE_MAX = 3'h7;

  // Register contents after reset; undefined on the device, zero here
  localparam logic [12:0] REG_RESET = 13'h0000;

  // DLL lock time in clocks
  localparam int DLL_LOCK_CLOCKS = 200;
  localparam int LOCK_CNT_W = 8;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } dmr_cmd_t;

  typedef struct packed {
    logic [2:0] burst_len;
    logic burst_interleave;
    logic [2:0] cas_lat;
    logic test_mode;
    logic [2:0] write_recovery;
    logic dll_disable;
    logic reduced_drive;
    logic [1:0] odt_sel;
    logic [2:0] add_lat;
    logic [2:0] ocd_mode;
    logic dqs_n_disable;
    logic rdqs_enable;
    logic outputs_off;
  } dmr_cfg_t;

endpackage : dmr_pkg

// File: logic/dmr_dll_lock.sv
// DLL lock timer: counts clocks after the DLL is enabled or reset
`timescale 1ns/10ps
`default_nettype none
module dmr_dll_lock #(
  parameter int LOCK_CYCLES = dmr_pkg::DLL_LOCK_CLOCKS
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic dll_on, // DLL enabled and powered
  input wire logic dll_reset, // One-cycle DLL reset request
  output logic locked // Lock time elapsed
);

  // Refuse lock times the counter cannot reach
  if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << dmr_pkg::LOCK_CNT_W)) begin : g_bad_lock
    $error("LOCK_CYCLES out of range for counter width");
  end

  localparam logic [dmr_pkg::LOCK_CNT_W-1:0] LOCK_END = dmr_pkg::LOCK_CNT_W'(LOCK_CYCLES);

  logic [dmr_pkg::LOCK_CNT_W-1:0] cnt_ff;
  logic locked_ff;

  // Any DLL reset or loss of enable restarts the wait
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      locked_ff <= 1'b0;
    end else if (!dll_on) begin
      cnt_ff <= '0;
      locked_ff <= 1'b0;
    end else if (dll_reset) begin
      cnt_ff <= '0;
      locked_ff <= 1'b0;
    end else if (!locked_ff && cnt_ff != '1) begin
      cnt_ff <= cnt_ff + 1'b1;
      if (cnt_ff == LOCK_END - 1'b1) begin
        locked_ff <= 1'b1;
      end
    end
  end

  assign locked = locked_ff;

endmodule : dmr_dll_lock
`default_nettype wire

// File: logic/dmr_top.sv
// Mode and extended mode register decode, DLL control and self-refresh tracking
// What this block does
// - Bank code 010 writes extended register two
// - Bank code 011 writes extended register three
// - Mode write with A8 high resets DLL
// - Mode write with A8 low keeps DLL
// - Mode writes never touch array contents
// - All-low command and bank captures A0..A12
// - Decode burst length, type, CAS latency
// - Decode test mode, DLL reset, write recovery
// - Decode DLL, drive, AL, OCD, strobe, ODT
// - Self refresh disables, exit re-enables DLL
// - A11 low disables redundant read strobe
`timescale 1ns/10ps
`default_nettype none
module dmr_top #(
  parameter int LOCK_CYCLES = dmr_pkg::DLL_LOCK_CLOCKS
) (
  input wire logic CLK_SYS, // Device clock, commands sampled on rising edge
  input wire logic RESET_N, // Async reset, active low, stands for power-up
  input wire dmr_pkg::dmr_cmd_t CMD_IN, // Command, bank and address pins
  output dmr_pkg::dmr_cfg_t MODE_CFG, // Decoded mode fields
  output logic [12:0] MR_OUT, // Operating mode register contents
  output logic [12:0] EMR1_OUT, // Extended register one contents
  output logic [12:0] EMR2_OUT, // Extended register two contents
  output logic [12:0] EMR3_OUT, // Extended register three contents
  output logic [3:0] PROGRAMMED, // Written since reset, bit per register
  output logic MODE_WRITE, // Pulse: a register was written
  output logic MODE_LEGAL, // Burst length and CAS latency supported
  output logic DLL_ACTIVE, // DLL enabled and running
  output logic DLL_RESET, // Pulse: DLL reset taking place
  output logic DLL_LOCKED, // DLL lock time elapsed
  output logic SELF_REFRESH // Device in self refresh
);

  typedef enum logic [2:0] {
    ST_CKE_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_SREF = 3'b100
  } dmr_state_t;

  function automatic logic is_mode_cmd(input dmr_pkg::dmr_cmd_t c);
    is_mode_cmd = !c.cs_n && !c.ras_n && !c.cas_n && !c.we_n;
  endfunction : is_mode_cmd

  function automatic logic is_refresh_cmd(input dmr_pkg::dmr_cmd_t c);
    is_refresh_cmd = !c.cs_n && !c.ras_n && !c.cas_n && c.we_n;
  endfunction : is_refresh_cmd

  dmr_state_t state_ff;
  dmr_state_t nxt_state;
  logic cke_prev_ff;
  logic [12:0] mr_ff;
  logic [12:0] emr1_ff;
  logic [12:0] emr2_ff;
  logic [12:0] emr3_ff;
  logic [3:0] prog_ff;
  logic write_ff;
  logic dll_rst_ff;
  logic cmd_taken;
  logic mode_wr;
  logic sref_entry;
  logic sref_exit;
  logic dll_on;

  // CKE registered high on this and the previous edge gates commands
  assign cmd_taken = (state_ff == ST_RUN) && cke_prev_ff && CMD_IN.cke;
  assign mode_wr = cmd_taken && is_mode_cmd(CMD_IN);
  assign sref_entry = (state_ff == ST_RUN) && cke_prev_ff && !CMD_IN.cke
                      && is_refresh_cmd(CMD_IN);
  assign sref_exit = (state_ff == ST_SREF) && CMD_IN.cke;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cke_prev_ff <= 1'b0;
    end else begin
      cke_prev_ff <= CMD_IN.cke;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_CKE_OFF: begin
        if (CMD_IN.cke) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sref_entry) begin
          nxt_state = ST_SREF;
        end else if (!CMD_IN.cke) begin
          nxt_state = ST_CKE_OFF;
        end
      end
      ST_SREF: begin
        if (sref_exit) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_CKE_OFF;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_CKE_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Whole-register replace on every write; array logic never sees these
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      mr_ff <= dmr_pkg::REG_RESET;
      emr1_ff <= dmr_pkg::REG_RESET;
      emr2_ff <= dmr_pkg::REG_RESET;
      emr3_ff <= dmr_pkg::REG_RESET;
    end else if (mode_wr) begin
      unique case (CMD_IN.ba)
        dmr_pkg::BA_MR: mr_ff <= CMD_IN.addr;
        dmr_pkg::BA_EMR1: emr1_ff <= CMD_IN.addr;
        dmr_pkg::BA_EMR2: emr2_ff <= CMD_IN.addr;
        dmr_pkg::BA_EMR3: emr3_ff <= CMD_IN.addr;
        default: begin
        end
      endcase
    end
  end

  // Bank codes with BA2 high address nothing and are dropped
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      prog_ff <= 4'h0;
      write_ff <= 1'b0;
    end else begin
      write_ff <= mode_wr && !CMD_IN.ba[2];
      if (mode_wr && !CMD_IN.ba[2]) begin
        prog_ff[CMD_IN.ba[1:0]] <= 1'b1;
      end
    end
  end

  // DLL reset only on A8 high in the operating register, or self-refresh exit
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      dll_rst_ff <= 1'b0;
    end else begin
      dll_rst_ff <= (mode_wr && CMD_IN.ba == dmr_pkg::BA_MR
                     && CMD_IN.addr[dmr_pkg::MR_DLLRST_POS])
                    || sref_exit;
    end
  end

  // A0 low enables; an unwritten register leaves the DLL off
  assign dll_on = prog_ff[1] && !emr1_ff[dmr_pkg::E1_DLL_POS]
                  && (state_ff != ST_SREF);

  dmr_dll_lock #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_dll_lock (
    .clk_sys(CLK_SYS),
    .reset_n(RESET_N),
    .dll_on(dll_on),
    .dll_reset(dll_rst_ff),
    .locked(DLL_LOCKED)
  );

  always_comb begin
    MODE_CFG.burst_len = mr_ff[dmr_pkg::MR_BL_LSB +: 3];
    MODE_CFG.burst_interleave = mr_ff[dmr_pkg::MR_BT_POS];
    MODE_CFG.cas_lat = mr_ff[dmr_pkg::MR_CL_LSB +: 3];
    MODE_CFG.test_mode = mr_ff[dmr_pkg::MR_TM_POS];
    MODE_CFG.write_recovery = mr_ff[dmr_pkg::MR_WR_LSB +: 3];
    MODE_CFG.dll_disable = emr1_ff[dmr_pkg::E1_DLL_POS];
    MODE_CFG.reduced_drive = emr1_ff[dmr_pkg::E1_DS_POS];
    MODE_CFG.odt_sel = {emr1_ff[dmr_pkg::E1_ODT1_POS], emr1_ff[dmr_pkg::E1_ODT0_POS]};
    MODE_CFG.add_lat = emr1_ff[dmr_pkg::E1_AL_LSB +: 3];
    MODE_CFG.ocd_mode = emr1_ff[dmr_pkg::E1_OCD_LSB +: 3];
    MODE_CFG.dqs_n_disable = emr1_ff[dmr_pkg::E1_DQSN_POS];
    MODE_CFG.rdqs_enable = emr1_ff[dmr_pkg::E1_RDQS_POS];
    MODE_CFG.outputs_off = emr1_ff[dmr_pkg::E1_QOFF_POS];
  end

  // Half-clock latencies and other burst lengths are flagged unsupported
  assign MODE_LEGAL = (mr_ff[dmr_pkg::MR_BL_LSB +: 3] == dmr_pkg::BL_CODE_4
                       || mr_ff[dmr_pkg::MR_BL_LSB +: 3] == dmr_pkg::BL_CODE_8)
                      && mr_ff[dmr_pkg::MR_CL_LSB +: 3] >= dmr_pkg::CL_CODE_MIN
                      && mr_ff[dmr_pkg::MR_CL_LSB +: 3] <= dmr_pkg::CL_CODE_MAX;

  assign MR_OUT = mr_ff;
  assign EMR1_OUT = emr1_ff;
  assign EMR2_OUT = emr2_ff;
  assign EMR3_OUT = emr3_ff;
  assign PROGRAMMED = prog_ff;
  assign MODE_WRITE = write_ff;
  assign DLL_ACTIVE = dll_on;
  assign DLL_RESET = dll_rst_ff;
  assign SELF_REFRESH = (state_ff == ST_SREF);

endmodule : dmr_top
`default_nettype wire

// File: testbench/dmr_ctl_model.sv
// Controller-side command driver for the mode-register block
`timescale 1ns/10ps
`default_nettype none
module dmr_ctl_model (
  input wire logic clk_sys, // Clock
  input wire logic cke_on, // Clock enable level
  input wire logic req, // Command valid
  input wire logic [3:0] op_n, // cs, ras, cas, we
  input wire logic [2:0] ba, // Bank code
  input wire logic [12:0] addr, // Whole register value
  output dmr_pkg::dmr_cmd_t cmd // Device pins
);
  logic [15:0] last_ff = 16'h0000;
  always_ff @(posedge clk_sys) begin
    if (req) begin
      last_ff <= {ba, addr};
    end
  end
  // Idle bus shows inverted last value so stale data never matches
  assign cmd = req ? {cke_on, op_n, ba, addr}
    : {cke_on, 4'hf, ~last_ff};
endmodule : dmr_ctl_model
`default_nettype wire

// File: testbench/dmr_top_asserts.sv
// Port assertions for the mode-register block
`timescale 1ns/10ps
`default_nettype none
module dmr_top_asserts #(
  parameter int LOCK_CYCLES = dmr_pkg::DLL_LOCK_CLOCKS
) (
  input wire logic CLK_SYS, // Clock
  input wire logic RESET_N, // Reset
  input wire dmr_pkg::dmr_cmd_t CMD_IN, // Command pins
  input wire dmr_pkg::dmr_cfg_t MODE_CFG, // Fields
  input wire logic [12:0] MR_OUT, // Mode
  input wire logic [12:0] EMR1_OUT, // Ext one
  input wire logic [12:0] EMR2_OUT, // Ext two
  input wire logic [12:0] EMR3_OUT, // Ext three
  input wire logic DLL_ACTIVE, // DLL on
  input wire logic DLL_RESET, // DLL reset
  input wire logic SELF_REFRESH // Self refresh
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  logic wr;
  // Run state is inferred from past cke and refresh flag
  assign wr = CMD_IN.cke && !CMD_IN.cs_n && !CMD_IN.ras_n && !CMD_IN.cas_n && !CMD_IN.we_n;
  sequence s_take;
    wr && !CMD_IN.ba[2] && !SELF_REFRESH && $past(CMD_IN.cke) && !$past(SELF_REFRESH)
      && $past(RESET_N);
  endsequence
  property p_mr; s_take ##0 CMD_IN.ba == 3'h0 |=> MR_OUT == $past(CMD_IN.addr); endproperty
  a_mr: assert property (p_mr) else $error("mode capture wrong");
  property p_e1; s_take ##0 CMD_IN.ba == 3'h1 |=> EMR1_OUT == $past(CMD_IN.addr); endproperty
  a_e1: assert property (p_e1) else $error("ext one capture wrong");
  property p_e23;
    s_take ##0 CMD_IN.ba[1] |=> ($past(CMD_IN.ba[0]) ? EMR3_OUT : EMR2_OUT) == $past(CMD_IN.addr);
  endproperty
  a_e23: assert property (p_e23) else $error("ext two or three wrong");
  property p_rst; s_take ##0 CMD_IN.ba == 3'h0 && CMD_IN.addr[8] |=> DLL_RESET; endproperty
  a_rst: assert property (p_rst) else $error("no DLL reset");
  property p_keep; s_take ##0 CMD_IN.ba == 3'h0 && !CMD_IN.addr[8] |=> !DLL_RESET; endproperty
  a_keep: assert property (p_keep) else $error("stray DLL reset");
  property p_fld;
    MODE_CFG.burst_len == MR_OUT[2:0] && MODE_CFG.cas_lat == MR_OUT[6:4]
      && MODE_CFG.test_mode == MR_OUT[7] && MODE_CFG.write_recovery == MR_OUT[11:9];
  endproperty
  a_fld: assert property (p_fld) else $error("mode fields wrong");
  property p_sref; SELF_REFRESH |-> !DLL_ACTIVE; endproperty
  a_sref: assert property (p_sref) else $error("DLL on in self refresh");
  property p_exit; SELF_REFRESH && CMD_IN.cke |=> DLL_RESET; endproperty
  a_exit: assert property (p_exit) else $error("no reset on exit");
  // Refresh with clock enable falling from high enters self refresh
  property p_ent;
    !SELF_REFRESH && $past(CMD_IN.cke) && $past(RESET_N) && !CMD_IN.cke && !CMD_IN.cs_n
      && !CMD_IN.ras_n && !CMD_IN.cas_n && CMD_IN.we_n |=> SELF_REFRESH;
  endproperty
  a_ent: assert property (p_ent) else $error("no self refresh entry");
  c_mrs: cover property (s_take ##0 CMD_IN.ba == 3'h0);
  c_ent: cover property ($rose(SELF_REFRESH));
  c_ext: cover property ($fell(SELF_REFRESH));
endmodule : dmr_top_asserts
bind dmr_top dmr_top_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.CLK_SYS, .RESET_N, .CMD_IN,
  .MODE_CFG, .MR_OUT, .EMR1_OUT, .EMR2_OUT, .EMR3_OUT, .DLL_ACTIVE, .DLL_RESET, .SELF_REFRESH);
`default_nettype wire

// File: testbench/dmr_top_tb.sv
// Self-checking bench for the mode-register block
`timescale 1ns/10ps
`default_nettype none
module dmr_top_tb;
  localparam int LOCK = 4;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cke_on = 1'b0;
  logic req = 1'b0;
  logic [3:0] op_n = 4'hf;
  logic [2:0] ba = 3'h0;
  logic [12:0] addr = 13'h0000;
  int err_total = 0;
  int num_checks = 0;
  int n_lock = 0;
  dmr_pkg::dmr_cmd_t cmd;
  dmr_pkg::dmr_cfg_t cfg;
  logic [12:0] mr, e1, e2, e3;
  logic [3:0] prog;
  logic wr_p, legal, dll_on, dll_rst, locked, sref;
  always #4 clk_sys = ~clk_sys;
  dmr_ctl_model ctl (.clk_sys(clk_sys), .cke_on(cke_on), .req(req), .op_n(op_n), .ba(ba),
    .addr(addr), .cmd(cmd));
  dmr_top #(.LOCK_CYCLES(LOCK)) dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CMD_IN(cmd),
    .MODE_CFG(cfg), .MR_OUT(mr), .EMR1_OUT(e1), .EMR2_OUT(e2), .EMR3_OUT(e3), .PROGRAMMED(prog),
    .MODE_WRITE(wr_p), .MODE_LEGAL(legal), .DLL_ACTIVE(dll_on), .DLL_RESET(dll_rst),
    .DLL_LOCKED(locked), .SELF_REFRESH(sref));
  task automatic chk(input string w, input logic [12:0] e, input logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic chkb(input string w, input logic e, input logic g);
    chk(w, {12'h000, e}, {12'h000, g});
  endtask : chkb
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic issue(input logic [3:0] o, input logic [2:0] b, input logic [12:0] a);
    @(posedge clk_sys);
    req <= 1'b1;
    op_n <= o;
    ba <= b;
    addr <= a;
    @(posedge clk_sys);
    req <= 1'b0;
    #1;
  endtask : issue
  task automatic conclude;
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk("reset mode", dmr_pkg::REG_RESET, mr);
    chk("reset written", 13'h0000, {9'h000, prog});
    chkb("reset not legal", 1'b0, legal);
    issue(4'h0, 3'h0, 13'h00ab);
    chk("mode with cke low", 13'h0000, mr);
    repeat (25000) tick();
    @(posedge clk_sys);
    cke_on <= 1'b1;
    repeat (50) tick();
    issue(4'h2, 3'h0, 13'h0400);
    chkb("precharge write", 1'b0, wr_p);
    issue(4'h0, 3'h2, 13'h0080);
    chk("ext two", 13'h0080, e2);
    issue(4'h0, 3'h3, 13'h0000);
    chkb("ext three written", 1'b1, prog[3]);
    chk("ext two kept", 13'h0080, e2);
    issue(4'h0, 3'h1, 13'h0000);
    chkb("dll active", 1'b1, dll_on);
    issue(4'h0, 3'h0, 13'h0132);
    chk("mode", 13'h0132, mr);
    chkb("write pulse", 1'b1, wr_p);
    chkb("dll reset", 1'b1, dll_rst);
    // Reset pulse is seen on the next edge, lock follows LOCK edges later
    n_lock = 0;
    while (locked !== 1'b1 && n_lock < LOCK + 3) begin
      tick();
      n_lock++;
    end
    chkb("dll locked", 1'b1, locked);
    chk("lock cycles", 13'(LOCK + 1), 13'(n_lock));
    issue(4'h2, 3'h0, 13'h0400);
    repeat (2) issue(4'h1, 3'h0, 13'h0000);
    chkb("refresh not sref", 1'b0, sref);
    issue(4'h0, 3'h0, 13'h0632);
    chkb("no dll reset", 1'b0, dll_rst);
    chk("burst len", {10'h000, dmr_pkg::BL_CODE_4}, {10'h000, cfg.burst_len});
    chk("cas lat", 13'h0003, {10'h000, cfg.cas_lat});
    chk("write rec", 13'h0003, {10'h000, cfg.write_recovery});
    chkb("legal", 1'b1, legal);
    issue(4'h0, 3'h1, 13'h0fca);
    chk("ocd default", 13'h0007, {10'h000, cfg.ocd_mode});
    issue(4'h0, 3'h1, 13'h0c4a);
    chk("ext one", 13'h0c4a, e1);
    chk("ocd exit", 13'h0000, {10'h000, cfg.ocd_mode});
    chk("add lat", 13'h0001, {10'h000, cfg.add_lat});
    chk("odt sel", 13'h0002, {11'h000, cfg.odt_sel});
    chkb("reduced drive", 1'b1, cfg.reduced_drive);
    chkb("read strobe", 1'b1, cfg.rdqs_enable);
    chkb("strobe off", 1'b1, cfg.dqs_n_disable);
    issue(4'h0, 3'h4, 13'h1fff);
    chkb("dropped write", 1'b0, wr_p);
    issue(4'h8, 3'h0, 13'h01ff);
    chk("mode kept", 13'h0632, mr);
    @(posedge clk_sys);
    req <= 1'b1;
    op_n <= 4'h1;
    ba <= 3'h0;
    cke_on <= 1'b0;
    @(posedge clk_sys);
    req <= 1'b0;
    #1;
    chkb("sref entry", 1'b1, sref);
    chkb("dll off in sref", 1'b0, dll_on);
    repeat (5) tick();
    chkb("lock lost in sref", 1'b0, locked);
    @(posedge clk_sys);
    cke_on <= 1'b1;
    tick();
    chkb("sref exit", 1'b0, sref);
    chkb("exit dll reset", 1'b1, dll_rst);
    chkb("dll back on", 1'b1, dll_on);
    tick();
    chkb("exit reset pulse", 1'b0, dll_rst);
    conclude();
  end
endmodule : dmr_top_tb
`default_nettype wire
